// ### verilog/dio_defines.vh
// Overview of operation
// - five inputs and three outputs, one bit each, bit0 is terminal one
// - input forcing takes every input level from the forced input value
// - forced input bit one means high level, zero means low level
// - input level monitor reads back the forced value while forcing
// - input forcing ends at reset or when force mode is written zero
// - output forcing takes every output state from forced output value
// - forced output bit is a function state; polarity gives the level
// - active-low outputs: state 110 gives levels 001, monitor reads 1
// - active-high outputs: levels equal state, 110 reads as 6
// - parameter output forcing ends at reset or force mode zero
// - force mode 4 lets the fieldbus output object set output levels
// - fieldbus bits 16 to 18 map to outputs; mask enables, bit is level
// - fieldbus output forcing ends at reset or force mode zero
// - with a password set, writes are refused until it is entered
// - lock bit5 plus password hides and locks groups above two
// - after authorisation, writing zero to password removes protection
// - on run start from status view, keypad shows monitor entry at default monitor offset
// - up/down change blinking digit, shift moves it, set stores
//
// Purpose: constants of the digital io override block
// Assumes: parameters addressed by group and offset
// Notes: force codes for input and output forcing are free constants
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH

`define DIO_GRP_PASS 8'h02
`define DIO_OFS_PASS 8'h1e
`define DIO_OFS_DEFMON 8'h20
`define DIO_GRP_LOCK 8'h0a
`define DIO_OFS_LOCK 8'h47
`define DIO_GRP_FORCE 8'h0d
`define DIO_OFS_FMODE 8'h11
`define DIO_OFS_FIN 8'h12
`define DIO_OFS_FOUT 8'h13
`define DIO_GRP_MON 8'h0b
`define DIO_OFS_SPEED 8'h00
`define DIO_OFS_INMON 8'h03
`define DIO_OFS_OUTMON 8'h05
`define DIO_GRP_OPEN_MAX 8'h02

`define DIO_MODE_NONE 8'h00
`define DIO_MODE_IN 8'h01
`define DIO_MODE_OUT 8'h02
`define DIO_MODE_BUS 8'h04

`define DIO_FB_LEVELS 2'h1
`define DIO_FB_MASK 2'h2
`define DIO_FB_LSB 16
`define DIO_FB_MSB 18

`define DIO_LOCK_BIT 5
`define DIO_SPD_FRAC 4
`define DIO_SPD_HALF 32'h00000008

`define DIO_DIGITS 5
`define DIO_DIGIT_MAX 4'h9
`define DIO_POS_LAST 3'h4

`endif

// ### verilog/dio_digit_editor.v
// Purpose: five digit decimal editor for the keypad
// Assumes: key inputs are one-cycle pulses
// Notes: value is loaded before editing from the shown default monitor, force mode or forced value; other parameters load zero
`include "dio_defines.vh"

module dio_digit_editor (
  input wire clk,
  input wire reset,
  input wire load,
  input wire [19:0] loadDigits,
  input wire keyUp,
  input wire keyDown,
  input wire keyShift,
  input wire keySet,
  output reg [19:0] digits,
  output reg [2:0] blinkPos,
  output reg store
);

  // ************************************
  // digit stepping
  // ************************************
  wire [3:0] cur;
  assign cur = digits[blinkPos*4 +: 4];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      digits <= 20'h00000;
      blinkPos <= 3'h0;
      store <= 1'b0;
    end else begin
      store <= keySet;
      if (load) begin
        digits <= loadDigits;
        blinkPos <= 3'h0;
      end else begin
        if (keyUp) begin
          // wraps inside one digit, no carry into the next
          digits[blinkPos*4 +: 4] <=
            (cur == `DIO_DIGIT_MAX) ? 4'h0 : cur + 4'h1;
        end else if (keyDown) begin
          digits[blinkPos*4 +: 4] <=
            (cur == 4'h0) ? `DIO_DIGIT_MAX : cur - 4'h1;
        end
        if (keyShift) begin
          blinkPos <= (blinkPos == `DIO_POS_LAST) ? 3'h0 :
            blinkPos + 3'h1;
        end
      end
    end
  end

endmodule

// ### verilog/dio_force_override.v
// Purpose: digital io force override, password lock and keypad monitor
// Assumes: all inputs synchronous to clk, key and access strobes are pulses
// Notes: nothing here survives reset, so forcing always ends at power-up
`include "dio_defines.vh"

module dio_force_override (
  input wire clk,
  input wire reset,
  input wire [4:0] inputPins,
  input wire [2:0] outputFunc,
  input wire [2:0] outputActiveHigh,
  output reg [4:0] inputLevel,
  output reg [2:0] outputPins,
  input wire parWr,
  input wire parRd,
  input wire [7:0] parGroup,
  input wire [7:0] parOffset,
  input wire [31:0] parWrData,
  output reg [31:0] parRdData,
  output reg parAck,
  output reg parDenied,
  output reg passwordError,
  output reg authorized,
  input wire fbWr,
  input wire fbRd,
  input wire [1:0] fbSub,
  input wire [31:0] fbWrData,
  output reg [31:0] fbRdData,
  output reg fbAck,
  input wire motorRunning,
  input wire [31:0] motorSpeed,
  input wire keyMode,
  input wire keyUp,
  input wire keyDown,
  input wire keyShift,
  input wire keySet,
  output reg showParam,
  output reg [7:0] showGroup,
  output reg [7:0] showOffset,
  output wire [19:0] editDigits,
  output wire [2:0] editBlink
);

  // ************************************
  // helpers
  // ************************************
  function [19:0] to_bcd;
    input [31:0] v;
    integer i;
    reg [16:0] n;
    reg [19:0] d;
    reg [16:0] r;
    begin
      n = v[16:0];
      d = 20'h00000;
      r = 17'd0;
      for (i = 0; i < `DIO_DIGITS; i = i + 1) begin
        r = n % 17'd10;
        d[i*4 +: 4] = r[3:0];
        n = n / 17'd10;
      end
      to_bcd = d;
    end
  endfunction

  function [31:0] from_bcd;
    input [19:0] d;
    integer i;
    reg [31:0] n;
    begin
      n = 32'h00000000;
      for (i = `DIO_DIGITS - 1; i >= 0; i = i - 1)
        n = n * 32'd10 + {28'h0000000, d[i*4 +: 4]};
      from_bcd = n;
    end
  endfunction

  function is_par;
    input [7:0] g;
    input [7:0] o;
    input [7:0] wantG;
    input [7:0] wantO;
    begin
      is_par = (g == wantG) && (o == wantO);
    end
  endfunction

  // ************************************
  // parameter storage
  // ************************************
  reg [7:0] forceMode;
  reg [4:0] forcedIn;
  reg [2:0] forcedOut;
  reg [31:0] fbLevels;
  reg [31:0] fbMask;
  reg [31:0] password;
  reg [31:0] lockConfig;
  reg [7:0] defMonitor;
  reg [31:0] speedMon;
  reg runPrev;

  // ************************************
  // input path
  // ************************************
  wire [4:0] next_inputLevel;
  // physical pins are ignored entirely while forcing
  assign next_inputLevel = (forceMode == `DIO_MODE_IN) ?
    forcedIn : inputPins;

  // ************************************
  // output path
  // ************************************
  wire [2:0] outState;
  wire [2:0] polLevel;
  wire [2:0] busMask;
  wire [2:0] next_outputPins;
  assign outState = (forceMode == `DIO_MODE_OUT) ?
    forcedOut : outputFunc;
  // active-low terminal inverts the function state
  assign polLevel = outState ^ ~outputActiveHigh;
  // fieldbus bits act on terminal levels, past the polarity stage
  assign busMask = (forceMode == `DIO_MODE_BUS) ?
    fbMask[`DIO_FB_MSB:`DIO_FB_LSB] : 3'h0;
  assign next_outputPins = (busMask & fbLevels[`DIO_FB_MSB:`DIO_FB_LSB]) |
    (~busMask & polLevel);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      inputLevel <= 5'h00;
      outputPins <= 3'h0;
    end else begin
      inputLevel <= next_inputLevel;
      outputPins <= next_outputPins;
    end
  end

  // ************************************
  // speed monitor
  // ************************************
  wire [31:0] spdBiased;
  wire [31:0] next_speedMon;
  // round to nearest, arithmetic shift keeps the sign
  assign spdBiased = motorSpeed + `DIO_SPD_HALF;
  assign next_speedMon = $signed(spdBiased) >>> `DIO_SPD_FRAC;

  // ************************************
  // access control
  // ************************************
  wire passSet;
  wire hideHigh;
  wire keyStore;
  wire [7:0] accG;
  wire [7:0] accO;
  wire accWr;
  wire [31:0] accData;
  wire accRd;
  wire isPass;
  wire grpHidden;
  wire wrAllowed;
  wire [19:0] storeDigits;
  assign passSet = (password != 32'h00000000);
  assign hideHigh = passSet && !authorized &&
    lockConfig[`DIO_LOCK_BIT];
  // a keypad store wins over a bus access in the same cycle
  assign accWr = keyStore | parWr;
  assign accRd = parRd & ~keyStore;
  assign accG = keyStore ? showGroup : parGroup;
  assign accO = keyStore ? showOffset : parOffset;
  assign accData = keyStore ? from_bcd(storeDigits) : parWrData;
  assign isPass = is_par(accG, accO, `DIO_GRP_PASS, `DIO_OFS_PASS);
  assign grpHidden = hideHigh && (accG > `DIO_GRP_OPEN_MAX);
  assign wrAllowed = !passSet || authorized;

  // ************************************
  // read mux
  // ************************************
  reg [31:0] rdVal;
  always @* begin
    rdVal = 32'h00000000;
    if (is_par(accG, accO, `DIO_GRP_PASS, `DIO_OFS_PASS))
      rdVal = 32'h00000000;
    else if (is_par(accG, accO, `DIO_GRP_PASS, `DIO_OFS_DEFMON))
      rdVal = {24'h000000, defMonitor};
    else if (is_par(accG, accO, `DIO_GRP_LOCK, `DIO_OFS_LOCK))
      rdVal = lockConfig;
    else if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FMODE))
      rdVal = {24'h000000, forceMode};
    else if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FIN))
      rdVal = {27'h0000000, forcedIn};
    else if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FOUT))
      rdVal = {29'h00000000, forcedOut};
    else if (is_par(accG, accO, `DIO_GRP_MON, `DIO_OFS_SPEED))
      rdVal = speedMon;
    else if (is_par(accG, accO, `DIO_GRP_MON, `DIO_OFS_INMON))
      rdVal = {27'h0000000, inputLevel};
    else if (is_par(accG, accO, `DIO_GRP_MON, `DIO_OFS_OUTMON))
      rdVal = {29'h00000000, outputPins};
  end

  // ************************************
  // parameter access
  // ************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      forceMode <= `DIO_MODE_NONE;
      forcedIn <= 5'h00;
      forcedOut <= 3'h0;
      password <= 32'h00000000;
      lockConfig <= 32'h00000000;
      defMonitor <= 8'h00;
      authorized <= 1'b0;
      parRdData <= 32'h00000000;
      parAck <= 1'b0;
      parDenied <= 1'b0;
      passwordError <= 1'b0;
      speedMon <= 32'h00000000;
    end else begin
      speedMon <= next_speedMon;
      parAck <= 1'b0;
      parDenied <= 1'b0;
      passwordError <= 1'b0;
      if (accRd) begin
        if (grpHidden) begin
          parDenied <= 1'b1;
          parRdData <= 32'h00000000;
        end else begin
          parAck <= 1'b1;
          parRdData <= rdVal;
        end
      end else if (accWr) begin
        if (isPass && !wrAllowed) begin
          // entering the password is the one write allowed while locked
          if (accData == password) begin
            authorized <= 1'b1;
            parAck <= 1'b1;
          end else begin
            passwordError <= 1'b1;
            parDenied <= 1'b1;
          end
        end else if (!wrAllowed || grpHidden) begin
          parDenied <= 1'b1;
        end else begin
          parAck <= 1'b1;
          if (isPass) begin
            password <= accData;
            // new password takes effect at once, a zero removes the lock
            authorized <= 1'b0;
          end
          if (is_par(accG, accO, `DIO_GRP_PASS, `DIO_OFS_DEFMON))
            defMonitor <= accData[7:0];
          if (is_par(accG, accO, `DIO_GRP_LOCK, `DIO_OFS_LOCK))
            lockConfig <= accData;
          if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FMODE))
            forceMode <= accData[7:0];
          if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FIN))
            forcedIn <= accData[4:0];
          if (is_par(accG, accO, `DIO_GRP_FORCE, `DIO_OFS_FOUT))
            forcedOut <= accData[2:0];
        end
      end
    end
  end

  // ************************************
  // fieldbus output object
  // ************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fbLevels <= 32'h00000000;
      fbMask <= 32'h00000000;
      fbRdData <= 32'h00000000;
      fbAck <= 1'b0;
    end else begin
      fbAck <= fbWr | fbRd;
      if (fbWr && fbSub == `DIO_FB_LEVELS)
        fbLevels <= fbWrData;
      if (fbWr && fbSub == `DIO_FB_MASK)
        fbMask <= fbWrData;
      if (fbRd) begin
        if (fbSub == `DIO_FB_LEVELS)
          fbRdData <= fbLevels;
        else if (fbSub == `DIO_FB_MASK)
          fbRdData <= fbMask;
        else
          fbRdData <= 32'h00000000;
      end
    end
  end

  // ************************************
  // keypad display selection
  // ************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      showParam <= 1'b0;
      showGroup <= 8'h00;
      showOffset <= 8'h00;
      runPrev <= 1'b0;
    end else begin
      runPrev <= motorRunning;
      if (motorRunning && !runPrev && !showParam) begin
        // only leaves status view, never steals an edit in progress
        showParam <= 1'b1;
        showGroup <= `DIO_GRP_MON;
        showOffset <= defMonitor;
      end else if (keyMode) begin
        showParam <= 1'b1;
        showGroup <= parGroup;
        showOffset <= parOffset;
      end else if (keyStore) begin
        showOffset <= showOffset + 8'h01;
      end
    end
  end

  // ************************************
  // digit editor
  // ************************************
  reg [31:0] loadVal;
  always @* begin
    loadVal = 32'h00000000;
    if (is_par(parGroup, parOffset, `DIO_GRP_PASS, `DIO_OFS_DEFMON))
      loadVal = {24'h000000, defMonitor};
    else if (is_par(parGroup, parOffset, `DIO_GRP_FORCE, `DIO_OFS_FMODE))
      loadVal = {24'h000000, forceMode};
    else if (is_par(parGroup, parOffset, `DIO_GRP_FORCE, `DIO_OFS_FIN))
      loadVal = {27'h0000000, forcedIn};
    else if (is_par(parGroup, parOffset, `DIO_GRP_FORCE, `DIO_OFS_FOUT))
      loadVal = {29'h00000000, forcedOut};
  end

  assign editDigits = storeDigits;

  dio_digit_editor u_editor (
    .clk(clk),
    .reset(reset),
    .load(keyMode),
    .loadDigits(to_bcd(loadVal)),
    .keyUp(keyUp),
    .keyDown(keyDown),
    .keyShift(keyShift),
    .keySet(keySet),
    .digits(storeDigits),
    .blinkPos(editBlink),
    .store(keyStore)
  );

endmodule

// ### tb/dio_force_chk.sv
// Purpose: port checker of the io override block
// Assumes: force settings shadowed from acked bus writes
// Notes: keypad stores are not shadowed, though a store to force mode changes it
// ****
// checker
// ****
`include "dio_defines.vh"
module dio_force_chk (
  input wire clk,
  input wire reset,
  input wire [4:0] inputPins,
  input wire [2:0] outputFunc,
  input wire [2:0] outputActiveHigh,
  input wire [4:0] inputLevel,
  input wire [2:0] outputPins,
  input wire parWr,
  input wire parRd,
  input wire [7:0] parGroup,
  input wire [7:0] parOffset,
  input wire [31:0] parWrData,
  input wire [31:0] parRdData,
  input wire parAck,
  input wire parDenied,
  input wire passwordError,
  input wire authorized,
  input wire fbWr,
  input wire fbRd,
  input wire [1:0] fbSub,
  input wire [31:0] fbWrData,
  input wire fbAck,
  input wire motorRunning,
  input wire keySet,
  input wire showParam,
  input wire [7:0] showGroup
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] md;
  logic [4:0] fi, inp;
  logic [2:0] fo, fm, fl, nrm;
  logic [1:0] up;
  logic pWr, pFbWr;
  logic [7:0] pGrp, pOfs;
  logic [31:0] pDat, pFbDat;
  logic [1:0] pSub;
  // outputs lag one cycle, so the shadows lag the same
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      md <= 8'h00;
      fi <= 5'h00;
      fo <= 3'h0;
      fm <= 3'h0;
      fl <= 3'h0;
      up <= 2'h0;
    end else begin
      up <= up + {1'b0, ~up[1]};
      if (parAck && pWr && pGrp == `DIO_GRP_FORCE) begin
        case (pOfs)
          `DIO_OFS_FMODE: md <= pDat[7:0];
          `DIO_OFS_FIN: fi <= pDat[4:0];
          `DIO_OFS_FOUT: fo <= pDat[2:0];
          default: ;
        endcase
      end
      if (fbAck && pFbWr && pSub == `DIO_FB_MASK)
        fm <= pFbDat[18:16];
      if (fbAck && pFbWr && pSub == `DIO_FB_LEVELS)
        fl <= pFbDat[18:16];
    end
  end
  // request copies, one cycle old when the answer arrives
  always @(posedge clk) begin
    inp <= inputPins;
    nrm <= outputFunc ^ ~outputActiveHigh;
    pWr <= parWr;
    pGrp <= parGroup;
    pOfs <= parOffset;
    pDat <= parWrData;
    pFbWr <= fbWr;
    pSub <= fbSub;
    pFbDat <= fbWrData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_in_force;
    md == `DIO_MODE_IN |-> inputLevel == fi;
  endproperty
  a_in_force: assert property (p_in_force)
    else $error("forced input level wrong");
  property p_norm;
    up[1] && md == `DIO_MODE_NONE |-> inputLevel == inp && outputPins == nrm;
  endproperty
  a_norm: assert property (p_norm)
    else $error("normal io path wrong");
  property p_out_force;
    md == `DIO_MODE_OUT |-> outputPins == (fo ^ ~$past(outputActiveHigh));
  endproperty
  a_out_force: assert property (p_out_force)
    else $error("forced output level wrong");
  property p_bus;
    md == `DIO_MODE_BUS |-> outputPins == ((fm & fl) | (~fm & nrm));
  endproperty
  a_bus: assert property (p_bus)
    else $error("fieldbus output level wrong");
  property p_answer;
    (parWr || parRd) && !$past(keySet) |=> parAck != parDenied;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered once");
  property p_pw_err;
    passwordError |-> parDenied && !authorized;
  endproperty
  a_pw_err: assert property (p_pw_err)
    else $error("wrong password accepted");
  property p_auth;
    $rose(authorized) |-> parAck;
  endproperty
  a_auth: assert property (p_auth)
    else $error("authorised without ack");
  property p_deny_rd;
    parDenied && $past(parRd) |-> parRdData == 32'h00000000;
  endproperty
  a_deny_rd: assert property (p_deny_rd)
    else $error("denied read leaks data");
  property p_fb;
    fbWr || fbRd |=> fbAck;
  endproperty
  a_fb: assert property (p_fb)
    else $error("fieldbus access not acked");
  property p_mon;
    $rose(motorRunning) && !showParam |-> ##[1:2]
      (showParam && showGroup == `DIO_GRP_MON);
  endproperty
  a_mon: assert property (p_mon)
    else $error("keypad did not show monitor");
  c_bus: cover property (md == `DIO_MODE_BUS && fm != 3'h0);
  c_pw: cover property (passwordError);
  c_run: cover property ($rose(showParam));
endmodule
bind dio_force_override dio_force_chk dio_force_chk_i (.*);

// ### tb/dio_host_model.sv
// Purpose: host controller on parameter and fieldbus ports
// Assumes: one access at a time, strobes one cycle
// Notes: waits bounded; a lost answer sets lost
// ****
// host
// ****
module dio_host_model (
  input logic clk,
  input logic parAck,
  input logic parDenied,
  input logic passwordError,
  input logic fbAck,
  output logic parWr,
  output logic parRd,
  output logic [7:0] parGroup,
  output logic [7:0] parOffset,
  output logic [31:0] parWrData,
  output logic fbWr,
  output logic fbRd,
  output logic [1:0] fbSub,
  output logic [31:0] fbWrData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lost = 1'b0;
  logic ack, den, perr;
  initial {parWr, parRd, parGroup, parOffset, parWrData} = '0;
  initial {fbWr, fbRd, fbSub, fbWrData} = '0;
  task automatic xfer(input logic w, input logic [7:0] g,
    input logic [7:0] o, input logic [31:0] d);
    int i;
    @(posedge clk);
    parWr <= w;
    parRd <= !w;
    parGroup <= g;
    parOffset <= o;
    parWrData <= d;
    @(posedge clk);
    parWr <= 1'b0;
    parRd <= 1'b0;
    parWrData <= ~d;
    i = 0;
    do begin @(negedge clk); i++; end while (!(parAck | parDenied) && i < 4);
    ack = parAck;
    den = parDenied;
    perr = passwordError;
    lost = lost | !(ack | den);
  endtask
  // mask and level words carry outputs in bits 16..18
  task automatic fb(input logic r, input logic [1:0] s, input logic [31:0] d);
    int i;
    @(posedge clk);
    fbWr <= !r;
    fbRd <= r;
    fbSub <= s;
    fbWrData <= d;
    @(posedge clk);
    fbWr <= 1'b0;
    fbRd <= 1'b0;
    fbWrData <= ~d;
    i = 0;
    do begin @(negedge clk); i++; end while (!fbAck && i < 4);
    lost = lost | !fbAck;
  endtask
endmodule

// ### tb/dio_force_override_test.sv
// Purpose: self checking bench of the io override block
// Assumes: host model makes all bus accesses
// Notes: keypad keys driven as one five bit vector
`include "dio_defines.vh"
module dio_force_override_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] GF = `DIO_GRP_FORCE;
  localparam logic [7:0] GM = `DIO_GRP_MON;
  localparam logic [7:0] GP = `DIO_GRP_PASS;
  localparam logic [2:0] A = 3'h4;
  localparam logic [2:0] D = 3'h2;
  logic clk, reset, motorRunning;
  logic [4:0] inputPins;
  logic [2:0] outputFunc, outputActiveHigh;
  logic [31:0] motorSpeed;
  wire parWr, parRd, fbWr, fbRd, parAck, parDenied, fbAck;
  wire passwordError, authorized, showParam;
  wire [7:0] parGroup, parOffset, showGroup, showOffset;
  wire [31:0] parWrData, fbWrData, parRdData, fbRdData;
  wire [1:0] fbSub;
  wire [4:0] inputLevel;
  wire [2:0] outputPins;
  wire [19:0] editDigits;
  wire [2:0] editBlink;
  // mode, up, down, shift, set from msb down
  logic [4:0] keys;
  int error_cnt = 0;
  int num_checks = 0;
  dio_force_override dio_force_override_i (.keyMode(keys[4]),
    .keyUp(keys[3]), .keyDown(keys[2]), .keyShift(keys[1]),
    .keySet(keys[0]), .editDigits(editDigits), .editBlink(editBlink), .*);
  dio_host_model dio_host_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic guard;
    if (dio_host_model_i.lost) begin
      error_cnt++;
      $display("Error %0t: no answer", $time);
      test_done;
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] g, input logic [7:0] o,
    input logic [31:0] d, input logic [2:0] e);
    dio_host_model_i.xfer(w, g, o, d);
    guard;
    chk({dio_host_model_i.ack, dio_host_model_i.den, dio_host_model_i.perr},
      e);
  endtask
  task automatic fb(input logic r, input logic [1:0] s, input logic [31:0] d);
    dio_host_model_i.fb(r, s, d);
    guard;
  endtask
  task automatic drv(input logic [4:0] p, input logic [2:0] f,
    input logic [2:0] h);
    @(posedge clk);
    inputPins <= p;
    outputFunc <= f;
    outputActiveHigh <= h;
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_input;
    drv(5'h01, 3'h1, 3'h7);
    acc(1, GF, `DIO_OFS_FIN, 32'h1e, A);
    acc(1, GF, `DIO_OFS_FMODE, `DIO_MODE_IN, A);
    settle;
    chk(inputLevel, 5'h1e);
    acc(0, GM, `DIO_OFS_INMON, 0, A);
    chk(parRdData, 32'h1e);
    acc(1, GF, `DIO_OFS_FMODE, 0, A);
    settle;
    chk(inputLevel, 5'h01);
    $display("t_input done");
  endtask
  task automatic t_output;
    drv(5'h01, 3'h1, 3'h0);
    acc(1, GF, `DIO_OFS_FOUT, 32'h6, A);
    acc(1, GF, `DIO_OFS_FMODE, `DIO_MODE_OUT, A);
    settle;
    chk(outputPins, 3'h1);
    acc(0, GM, `DIO_OFS_OUTMON, 0, A);
    chk(parRdData, 32'h1);
    drv(5'h01, 3'h1, 3'h7);
    settle;
    chk(outputPins, 3'h6);
    drv(5'h01, 3'h1, 3'h5);
    settle;
    chk(outputPins, 3'h4);
    acc(1, GF, `DIO_OFS_FMODE, 0, A);
    settle;
    chk(outputPins, 3'h3);
    $display("t_output done");
  endtask
  task automatic t_password;
    acc(1, GP, `DIO_OFS_PASS, 32'h1, A);
    acc(1, GF, `DIO_OFS_FMODE, 0, D);
    acc(1, GP, `DIO_OFS_PASS, 32'h2, 3'h3);
    acc(1, GP, `DIO_OFS_PASS, 32'h1, A);
    chk(authorized, 1'b1);
    acc(1, GF, `DIO_OFS_FIN, 32'h15, A);
    acc(1, `DIO_GRP_LOCK, `DIO_OFS_LOCK, 32'h20, A);
    acc(1, GP, `DIO_OFS_PASS, 32'h1, A);
    chk(authorized, 1'b0);
    acc(0, GF, `DIO_OFS_FIN, 0, D);
    chk(parRdData, 32'h0);
    acc(0, GP, `DIO_OFS_DEFMON, 0, A);
    acc(1, GP, `DIO_OFS_PASS, 32'h1, A);
    acc(1, GP, `DIO_OFS_PASS, 32'h0, A);
    acc(0, GF, `DIO_OFS_FIN, 0, A);
    chk(parRdData, 32'h15);
    $display("t_password done");
  endtask
  task automatic t_bus;
    drv(5'h01, 3'h6, 3'h7);
    acc(1, GF, `DIO_OFS_FMODE, `DIO_MODE_BUS, A);
    fb(0, `DIO_FB_MASK, 32'h00070000);
    fb(0, `DIO_FB_LEVELS, 32'h00010000);
    settle;
    chk(outputPins, 3'h1);
    fb(1, `DIO_FB_MASK, 0);
    chk(fbRdData, 32'h00070000);
    fb(0, `DIO_FB_MASK, 32'h00010000);
    settle;
    chk(outputPins, 3'h7);
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    settle;
    chk(outputPins, 3'h6);
    acc(0, GF, `DIO_OFS_FMODE, 0, A);
    chk(parRdData, 32'h0);
    $display("t_bus done");
  endtask
  task automatic t_monitor;
    acc(1, GP, `DIO_OFS_DEFMON, 32'h3, A);
    @(posedge clk) motorRunning <= 1'b1;
    settle;
    chk({showParam, showGroup, showOffset}, {1'b1, GM, 8'h03});
    @(posedge clk) motorSpeed <= 32'd48008;
    acc(0, GM, `DIO_OFS_SPEED, 0, A);
    chk(parRdData, 32'd3001);
    @(posedge clk) motorSpeed <= 32'hffff4468;
    acc(0, GM, `DIO_OFS_SPEED, 0, A);
    chk(parRdData, 32'hfffff447);
    $display("t_monitor done");
  endtask
  // one-cycle key pulse, returns after the edge that samples it; a set store lands one edge later
  task automatic press(input logic [4:0] k);
    @(posedge clk);
    keys <= k;
    @(posedge clk);
    keys <= 5'h00;
    @(negedge clk);
  endtask
  task automatic t_keypad;
    acc(1, GF, `DIO_OFS_FIN, 32'h7, A);
    press(5'h10);
    chk({showGroup, showOffset}, {GF, `DIO_OFS_FIN});
    chk(editDigits, 20'h00007);
    repeat (3) press(5'h08);
    chk(editDigits, 20'h00000);
    press(5'h04);
    chk(editDigits, 20'h00009);
    press(5'h02);
    press(5'h08);
    chk({editBlink, editDigits}, {3'h1, 20'h00019});
    press(5'h01);
    acc(0, GF, `DIO_OFS_FIN, 0, A);
    chk({showOffset, parRdData}, {8'h13, 32'h13});
    $display("t_keypad done");
  endtask
  initial begin
    {reset, motorRunning, inputPins, outputFunc, outputActiveHigh,
      motorSpeed, keys} = {1'b1, 49'h0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_input;
    t_output;
    t_password;
    t_bus;
    t_monitor;
    t_keypad;
    test_done;
  end
endmodule
